/* design/sync_level.sv */
// Purpose: two-flop synchroniser for a level from a pin
// Assumes: input asynchronous to clk
// Notes: only the second flop is visible outside
`timescale 1ns/100ps
module sync_level (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // level in and out
    input wire logic din,
    output logic dout
);
    logic meta;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta <= 1'b1;
            dout <= 1'b1;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule : sync_level

/* design/throttle_pkg.sv */
// Purpose: shared constants and types for the throttle time monitor
// Assumes: 100 MHz core clock, 8-bit register port from the serial engine
// Notes: temperatures carry two fraction bits (0.25 degree steps)
package throttle_pkg;

    // register offsets
    localparam logic [7:0] ADDR_CONFIG3 = 8'h02;
    localparam logic [7:0] ADDR_TIMER = 8'h0f;
    localparam logic [7:0] ADDR_STATUS2 = 8'h11;
    localparam logic [7:0] ADDR_MASK2 = 8'h13;
    localparam logic [7:0] ADDR_LIMIT = 8'h1e;
    localparam logic [7:0] ADDR_CRIT_TH1 = 8'h1f;
    localparam logic [7:0] ADDR_CRIT_TH2 = 8'h20;
    localparam logic [7:0] ADDR_CRIT_REM = 8'h21;
    localparam logic [7:0] ADDR_CRIT_LOC = 8'h22;

    // field positions
    localparam int STAT_OVT_BIT = 0;
    localparam int STAT_THROTTLE_LIMIT_FLAG_BIT = 1;
    localparam logic [1:0] PIN_MODE_OVERTEMP = 2'h1;

    // reset values
    localparam logic [7:0] CONFIG3_RESET = 8'h00;
    localparam logic [5:0] MASK2_RESET = 6'h00;
    localparam logic [7:0] LIMIT_RESET = 8'h00;
    localparam logic [7:0] CRIT_RESET = 8'h64;

    // timer encoding and time base
    localparam int unsigned CLK_HZ = 100000000;
    localparam int unsigned LSB_TIME_MS = 25;
    localparam int unsigned LSB_CYCLES = LSB_TIME_MS * (CLK_HZ / 1000);
    localparam logic [7:0] TWO_STAGE_TICKS = 8'h02;
    localparam logic [7:0] TIMER_FULL = 8'hff;

    // one register access from the serial engine
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } reg_req_t;

    // measurement results: th1, th2, remote, local
    typedef struct packed {
        logic [3:0][9:0] temp;
        logic [3:0] valid;
    } meas_t;

    // bit 0 marks an assertion until 50 ms, then the count takes over
    function automatic logic [7:0] timer_encode(input logic seen,
                                                input logic [7:0] ticks);
        timer_encode = (ticks >= TWO_STAGE_TICKS) ? ticks : {7'h00, seen};
    endfunction : timer_encode

    // exceeded by a quarter degree or more
    function automatic logic temp_over(input logic [9:0] temp,
                                       input logic [7:0] limit);
        temp_over = temp > {limit, 2'h0};
    endfunction : temp_over

endpackage : throttle_pkg

/* design/throttle_time_monitor.sv */
// Purpose: throttle assertion timer, limit flag and over-temperature pin
// Assumes: register port and measurements come from logic on clk
// Notes: shared pin is input in monitor mode, open-drain low otherwise
`timescale 1ns/100ps
module throttle_time_monitor #(
    parameter int unsigned LSB_CYCLES = throttle_pkg::LSB_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // register port
    input wire throttle_pkg::reg_req_t req,
    output logic [7:0] rdata,
    // measurement results
    input wire throttle_pkg::meas_t meas,
    // shared throttle / over-temperature pin
    input wire logic cpu_throttle_in,
    output logic overtemp_out,
    output logic overtemp_oe_n,
    // alert pin, open drain
    output logic alert_out,
    output logic alert_oe_n
);
    logic [7:0] config3;
    logic [5:0] mask2;
    logic [7:0] limit;
    logic [7:0] crit [4];
    logic [7:0] ticks;
    logic seen;
    logic throttle_sync;
    logic active_q;
    logic [3:0] hot;
    logic throttle_limit_flag_flag;
    logic ovt_flag;

    // pin mode and synchronised throttle level
    wire mode_overtemp = config3[1:0] == throttle_pkg::PIN_MODE_OVERTEMP;
    wire active = !throttle_sync && !mode_overtemp;
    wire start = active && !active_q;

    // register decode
    wire timer_read = req.rd && req.addr == throttle_pkg::ADDR_TIMER;
    wire status_read = req.rd && req.addr == throttle_pkg::ADDR_STATUS2;
    wire config_wr = req.wr && req.addr == throttle_pkg::ADDR_CONFIG3;
    wire mask_wr = req.wr && req.addr == throttle_pkg::ADDR_MASK2;
    wire limit_wr = req.wr && req.addr == throttle_pkg::ADDR_LIMIT;
    wire crit_hit = req.addr >= throttle_pkg::ADDR_CRIT_TH1 &&
                    req.addr <= throttle_pkg::ADDR_CRIT_LOC;
    wire crit_wr = req.wr && crit_hit;
    wire [7:0] crit_off = req.addr - throttle_pkg::ADDR_CRIT_TH1;
    wire [1:0] crit_idx = crit_off[1:0];

    // timer value and limit compare
    wire tick;
    wire [7:0] timer_value = throttle_pkg::timer_encode(seen, ticks);
    wire throttle_limit_flag_cond = timer_value > limit;
    wire ticks_full = ticks == throttle_pkg::TIMER_FULL;
    wire overtemp_any = |hot;

    wire [7:0] next_ticks = timer_read ? 8'h00 :
                            (tick && !ticks_full) ? ticks + 8'h01 :
                            ticks;
    wire next_seen = timer_read ? active : (seen || start);
    wire next_throttle_limit_flag = timer_read ? 1'b0 :
                     throttle_limit_flag_cond || (throttle_limit_flag_flag && !status_read);
    wire next_ovt = overtemp_any || (ovt_flag && !status_read);
    wire next_alert = (throttle_limit_flag_flag && !mask2[throttle_pkg::STAT_THROTTLE_LIMIT_FLAG_BIT]) ||
                      (ovt_flag && !mask2[throttle_pkg::STAT_OVT_BIT]);

    wire [7:0] status_value = {6'h00, throttle_limit_flag_flag, ovt_flag};
    wire [7:0] next_rdata =
        !req.rd ? rdata :
        req.addr == throttle_pkg::ADDR_CONFIG3 ? config3 :
        req.addr == throttle_pkg::ADDR_TIMER ? timer_value :
        req.addr == throttle_pkg::ADDR_STATUS2 ? status_value :
        req.addr == throttle_pkg::ADDR_MASK2 ? {2'h0, mask2} :
        req.addr == throttle_pkg::ADDR_LIMIT ? limit :
        crit_hit ? crit[crit_idx] : 8'h00;

    sync_level u_sync (
        .clk(clk),
        .rstn(rstn),
        .din(cpu_throttle_in),
        .dout(throttle_sync)
    );

    tick_divider #(
        .COUNT(LSB_CYCLES)
    ) u_tick (
        .clk(clk),
        .rstn(rstn),
        .run(active),
        .clear(timer_read),
        .tick(tick)
    );

    // control registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            config3 <= throttle_pkg::CONFIG3_RESET;
            mask2 <= throttle_pkg::MASK2_RESET;
            limit <= throttle_pkg::LIMIT_RESET;
        end else begin
            if (config_wr) config3 <= req.wdata;
            if (mask_wr) mask2 <= req.wdata[5:0];
            if (limit_wr) limit <= req.wdata;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 4; i++) crit[i] <= throttle_pkg::CRIT_RESET;
        end else if (crit_wr) begin
            crit[crit_idx] <= req.wdata;
        end
    end

    // timer state
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ticks <= 8'h00;
            seen <= 1'b0;
            active_q <= 1'b0;
        end else begin
            ticks <= next_ticks;
            seen <= next_seen;
            active_q <= active;
        end
    end

    // per-channel over-limit, updated only on a new measurement
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hot <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (meas.valid[i]) begin
                    hot[i] <= throttle_pkg::temp_over(meas.temp[i],
                                                      crit[i]);
                end
            end
        end
    end

    // sticky flags and pins
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            throttle_limit_flag_flag <= 1'b0;
            ovt_flag <= 1'b0;
            alert_out <= 1'b0;
            alert_oe_n <= 1'b1;
            overtemp_out <= 1'b0;
            overtemp_oe_n <= 1'b1;
            rdata <= 8'h00;
        end else begin
            throttle_limit_flag_flag <= next_throttle_limit_flag;
            ovt_flag <= next_ovt;
            alert_oe_n <= !next_alert;
            overtemp_oe_n <= !(mode_overtemp && overtemp_any);
            rdata <= next_rdata;
        end
    end

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    sequence s_read_active;
        timer_read && active;
    endsequence

    sequence s_restart;
        timer_value == 8'h01 && ticks == 8'h00;
    endsequence

    a_timer_halt: assert property (
        !active && !timer_read |=> $stable(ticks))
        else $error("timer moved while throttle idle");
    a_timer_resume: assert property (
        tick && !timer_read && !ticks_full |=> ticks == $past(ticks) + 8'h01)
        else $error("timer did not advance on tick");
    a_timer_saturate: assert property (
        ticks_full && !timer_read |=> ticks_full)
        else $error("timer left full scale without read");
    a_first_assert: assert property (
        start && !timer_read |=> timer_value != 8'h00)
        else $error("bit 0 not set on first assertion");
    a_read_clears: assert property (
        timer_read && !active |=> timer_value == 8'h00)
        else $error("timer not cleared by read");
    a_read_restart: assert property (
        s_read_active |=> s_restart)
        else $error("read during assertion did not restart timer");
    a_flag_read_clear: assert property (
        timer_read |=> !throttle_limit_flag_flag)
        else $error("limit flag survived timer read");
    a_limit_set: assert property (
        throttle_limit_flag_cond && !timer_read |=> throttle_limit_flag_flag ##1 !alert_oe_n ||
        mask2[throttle_pkg::STAT_THROTTLE_LIMIT_FLAG_BIT])
        else $error("limit exceeded without flag or alert");
    a_alert_masked: assert property (
        throttle_limit_flag_flag && mask2[throttle_pkg::STAT_THROTTLE_LIMIT_FLAG_BIT] && !ovt_flag
        |=> alert_oe_n)
        else $error("masked limit flag drove alert");
    a_flag_sticky: assert property (
        throttle_limit_flag_flag && !status_read && !timer_read |=> throttle_limit_flag_flag)
        else $error("limit flag dropped without read");
    a_overtemp_drive: assert property (
        mode_overtemp && overtemp_any |=> !overtemp_oe_n && !overtemp_out)
        else $error("overtemp pin not driven low");
    a_monitor_release: assert property (
        !mode_overtemp |=> overtemp_oe_n)
        else $error("pin driven in monitor mode");

    // timer encoding and limit flag
    sequence s_first_edge;
        (start && !timer_read) ##1 (!timer_read && limit == 8'h00);
    endsequence

    sequence s_reread_zero;
        s_read_active ##1 (!timer_read && limit == 8'h00);
    endsequence

    sequence s_pin_low_twice;
        !cpu_throttle_in ##1 !cpu_throttle_in;
    endsequence

    a_idle_no_tick: assert property (
        !active |-> !tick)
        else $error("time base ticked while throttle idle");
    a_mark_to_count: assert property (
        tick && ticks == 8'h01 && !timer_read |=> timer_value == 8'h02)
        else $error("threshold did not move to count encoding");
    a_lsb_count: assert property (
        tick && ticks == 8'h02 && !timer_read |=> timer_value == 8'h03)
        else $error("bit 0 not used as count lsb");
    a_limit_zero: assert property (
        s_first_edge |=> throttle_limit_flag_flag)
        else $error("zero limit did not flag first assertion");
    a_reread_zero: assert property (
        s_reread_zero |=> throttle_limit_flag_flag)
        else $error("limit flag not set again after read");

    // alert and over-temperature
    a_alert_drive: assert property (
        throttle_limit_flag_flag && !mask2[throttle_pkg::STAT_THROTTLE_LIMIT_FLAG_BIT] |=> !alert_oe_n)
        else $error("unmasked limit flag did not drive alert");
    a_alert_idle: assert property (
        !throttle_limit_flag_flag && !ovt_flag |=> alert_oe_n)
        else $error("alert driven with no flag set");
    a_ovt_set: assert property (
        overtemp_any |=> ovt_flag)
        else $error("over-temperature flag not set");
    a_ovt_sticky: assert property (
        ovt_flag && !status_read |=> ovt_flag)
        else $error("over-temperature flag dropped without read");
    a_hot_hold: assert property (
        overtemp_any && meas.valid == 4'h0 |=> overtemp_any)
        else $error("over-limit state dropped without a new reading");
    a_hot_clear: assert property (
        meas.valid[0] && meas.temp[0] <= {crit[0], 2'h0} |=> !hot[0])
        else $error("reading at limit did not clear over-limit");

    // register map and input path
    a_remote_slot: assert property (
        req.wr && req.addr == throttle_pkg::ADDR_CRIT_REM
        |=> crit[2] == $past(req.wdata))
        else $error("remote critical limit not written");
    a_limit_write: assert property (
        limit_wr |=> limit == $past(req.wdata))
        else $error("throttle limit not written");
    a_limit_only: assert property (
        req.wr && req.addr != throttle_pkg::ADDR_LIMIT |=> $stable(limit))
        else $error("throttle limit changed by another offset");
    a_sync_two: assert property (
        s_pin_low_twice |=> !throttle_sync)
        else $error("throttle level not through two flops");
    a_start_once: assert property (
        start |=> !start)
        else $error("assertion edge seen twice");

endmodule : throttle_time_monitor

/* design/tick_divider.sv */
// Purpose: time base that pulses once per COUNT cycles of run
// Assumes: clear has priority over run
// Notes: holds its phase while run is low
`timescale 1ns/100ps
module tick_divider #(
    parameter int unsigned COUNT = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // control
    input wire logic run,
    input wire logic clear,
    // one-cycle enable
    output logic tick
);
    localparam int W = $clog2(COUNT + 1);
    localparam logic [W-1:0] LAST = W'(COUNT - 1);

    logic [W-1:0] cnt;
    wire at_last = cnt == LAST;

    assign tick = run && at_last && !clear;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt <= '0;
        end else if (clear) begin
            cnt <= '0;
        end else if (run) begin
            cnt <= at_last ? '0 : cnt + W'(1);
        end
    end
endmodule : tick_divider

/* verification/testbench.sv */
// Purpose: self-checking bench for the throttle time monitor
// Assumes: LSB_CYCLES shortened to 8 so a timer step is 8 cycles
// Notes: each scenario except t_accum starts from a fresh reset; t_accum runs straight after t_reset
`timescale 1ns/100ps
module testbench;
    localparam int unsigned LSB = 8;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    throttle_pkg::reg_req_t req = '0;
    throttle_pkg::meas_t meas = '0;
    logic [7:0] rdata;
    logic [7:0] d;
    logic hold_low = 1'b0;
    logic pin, ot_out, ot_oe_n, al_out, al_oe_n;
    int fail_count = 0;
    int n_checks = 0;

    always #5 clk = ~clk;

    throttle_time_monitor #(.LSB_CYCLES(LSB)) DUT (
        .clk(clk), .rstn(rstn), .req(req), .rdata(rdata), .meas(meas),
        .cpu_throttle_in(pin), .overtemp_out(ot_out),
        .overtemp_oe_n(ot_oe_n), .alert_out(al_out), .alert_oe_n(al_oe_n));
    throttle_source partner (
        .hold_low(hold_low), .overtemp_oe_n(ot_oe_n), .pin(pin));

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize

    task automatic do_reset();
        @(negedge clk);
        rstn = 1'b0;
        hold_low = 1'b0;
        req = '0;
        meas = '0;
        repeat (12) @(negedge clk);
        rstn = 1'b1;
        @(negedge clk);
    endtask : do_reset

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: v};
        @(negedge clk);
        req = '0;
        @(negedge clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(negedge clk);
        req = '0;
        v = rdata;
        @(negedge clk);
    endtask : rd

    // pin low for n cycles, then let the synchroniser drain
    task automatic pulse(input int n);
        hold_low = 1'b1;
        repeat (n) @(negedge clk);
        hold_low = 1'b0;
        repeat (4) @(negedge clk);
    endtask : pulse

    task automatic meas_put(input int i, input logic [9:0] t);
        meas.temp[i] = t;
        meas.valid[i] = 1'b1;
        @(negedge clk);
        meas.valid = '0;
        repeat (3) @(negedge clk);
    endtask : meas_put

    task automatic t_reset();
        rd(throttle_pkg::ADDR_LIMIT, d);
        check("limit reset", d, throttle_pkg::LIMIT_RESET);
        for (int i = 0; i < 4; i++) begin
            rd(throttle_pkg::ADDR_CRIT_TH1 + 8'(i), d);
            check("crit reset", d, throttle_pkg::CRIT_RESET);
        end
        wr(throttle_pkg::ADDR_TIMER, 8'hff);
        rd(throttle_pkg::ADDR_TIMER, d);
        check("timer not writable", d, 8'h00);
        rd(8'h05, d);
        check("unmapped", d, 8'h00);
    endtask : t_reset

    task automatic t_accum();
        pulse(10);
        repeat (30) @(negedge clk);
        pulse(10);
        rd(throttle_pkg::ADDR_TIMER, d);
        check("accumulated", d, 8'h02);
    endtask : t_accum

    task automatic t_sat();
        pulse(2100);
        rd(throttle_pkg::ADDR_TIMER, d);
        check("saturated", d, 8'hff);
        rd(throttle_pkg::ADDR_TIMER, d);
        check("cleared", d, 8'h00);
    endtask : t_sat

    task automatic t_limit();
        wr(throttle_pkg::ADDR_LIMIT, 8'h01);
        rd(throttle_pkg::ADDR_LIMIT, d);
        check("limit written", d, 8'h01);
        rd(throttle_pkg::ADDR_CRIT_REM, d);
        check("remote apart", d, throttle_pkg::CRIT_RESET);
        pulse(10);
        rd(throttle_pkg::ADDR_STATUS2, d);
        check("flag below", d, 8'h00);
        check("alert below", {7'h00, al_oe_n}, 8'h01);
        pulse(10);
        rd(throttle_pkg::ADDR_STATUS2, d);
        check("flag above", d, 8'h02);
        check("alert above", {7'h00, al_oe_n}, 8'h00);
        rd(throttle_pkg::ADDR_TIMER, d);
        check("timer two", d, 8'h02);
        repeat (3) @(negedge clk);
        check("alert gone", {7'h00, al_oe_n}, 8'h01);
        rd(throttle_pkg::ADDR_STATUS2, d);
        check("flag cleared", d, 8'h00);
    endtask : t_limit

    task automatic t_zero();
        hold_low = 1'b1;
        repeat (7) @(negedge clk);
        check("alert first", {7'h00, al_oe_n}, 8'h00);
        rd(throttle_pkg::ADDR_TIMER, d);
        check("first mark", d, 8'h01);
        repeat (2) @(negedge clk);
        rd(throttle_pkg::ADDR_STATUS2, d);
        check("flag again", d, 8'h02);
        rd(throttle_pkg::ADDR_TIMER, d);
        check("restart", d, 8'h01);
        hold_low = 1'b0;
        repeat (4) @(negedge clk);
    endtask : t_zero

    task automatic t_mask();
        wr(throttle_pkg::ADDR_MASK2, 8'h02);
        pulse(10);
        check("masked alert", {7'h00, al_oe_n}, 8'h01);
        rd(throttle_pkg::ADDR_STATUS2, d);
        check("masked flag", d, 8'h02);
    endtask : t_mask

    task automatic t_overtemp();
        logic [7:0] lim;
        wr(throttle_pkg::ADDR_CONFIG3, 8'h01);
        for (int i = 0; i < 4; i++) begin
            lim = 8'h40 + 8'(i);
            wr(throttle_pkg::ADDR_CRIT_TH1 + 8'(i), lim);
            meas_put(i, {lim, 2'h0});
            check("equal", {7'h00, ot_oe_n}, 8'h01);
            meas_put(i, {lim, 2'h1});
            check("over", {7'h00, ot_oe_n}, 8'h00);
            check("ot level", {7'h00, ot_out}, 8'h00);
            check("ovt alert", {7'h00, al_oe_n}, 8'h00);
            check("alert level", {7'h00, al_out}, 8'h00);
            meas_put(i, {lim, 2'h0});
            check("back", {7'h00, ot_oe_n}, 8'h01);
        end
        rd(throttle_pkg::ADDR_TIMER, d);
        check("pin ignored", d, 8'h00);
        rd(throttle_pkg::ADDR_STATUS2, d);
        check("ovt sticky", d, 8'h01);
        rd(throttle_pkg::ADDR_STATUS2, d);
        check("ovt cleared", d, 8'h00);
    endtask : t_overtemp

    initial begin
        repeat (100000) @(posedge clk);
        fail_count++;
        summarize();
    end

    initial begin
        do_reset();
        t_reset();
        t_accum();
        do_reset();
        t_sat();
        do_reset();
        t_limit();
        do_reset();
        t_zero();
        do_reset();
        t_mask();
        do_reset();
        t_overtemp();
        summarize();
    end
endmodule : testbench

/* verification/throttle_source.sv */
// Purpose: processor throttle output on the shared pin
// Assumes: pin pulled up; hold_low changes at the falling edge
// Notes: the monitor also pulls the pin low in output mode
`timescale 1ns/100ps
module throttle_source (
    // bench control
    input wire logic hold_low,
    // monitor drive, low = pull low
    input wire logic overtemp_oe_n,
    // shared pin
    output logic pin
);
    // open drain: either party pulls low, else the pull-up wins
    assign pin = !(hold_low || !overtemp_oe_n);
endmodule : throttle_source
